/* File: shared/adc_seq_consts.vh */
// Purpose: constants for the converter sequencer
// Assumes: byte offsets are four times the printed register index
// Notes:   definitions only
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
// ***********************************************
// register indices and byte addresses
// ***********************************************
`define IDX_CTRL_A        8'h0e
`define IDX_TIMING        8'h0f
`define IDX_RES_UPPER     8'h20
`define IDX_RES_LOWER     8'h21
`define IDX_STANDBY       8'h30
`define ADDR_CTRL_A       12'h038
`define ADDR_TIMING       12'h03c
`define ADDR_RES_UPPER    12'h080
`define ADDR_RES_LOWER    12'h084
`define ADDR_STANDBY      12'h0c0
// ***********************************************
// field positions and reset values
// ***********************************************
`define CTRL_START_BIT    7
`define CTRL_MODE_HI      6
`define CTRL_MODE_LO      5
`define CTRL_AIN_DIS_BIT  4
`define TIM_LADDER_BIT    5
`define CTRL_A_RESET      8'h10
`define TIMING_RESET      8'h10
`define MODE_DISABLE      2'h0
`define MODE_SINGLE       2'h1
`define MODE_REPEAT       2'h3
// ***********************************************
// conversion times in system clocks
// ***********************************************
`define CONV_T0           11'd39
`define CONV_T2           11'd78
`define CONV_T3           11'd156
`define CONV_T4           11'd312
`define CONV_T5           11'd624
`define CONV_T6           11'd1248
`endif

/* File: src/conv_timer.v */
// Purpose: counts system clocks of one conversion
// Assumes: load starts a fresh count, abort clears it
// Notes:   reserved codes fall back to the shortest time
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module conv_timer (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // control
  input  wire       load,
  input  wire       abort,
  input  wire [2:0] time_sel,
  // status
  output reg        done
);
  reg  [10:0] count;
  reg  [10:0] limit;
  reg         run;

  // duration decode from the time select code
  always @* begin
    case (time_sel)
      3'h2:    limit = `CONV_T2;
      3'h3:    limit = `CONV_T3;
      3'h4:    limit = `CONV_T4;
      3'h5:    limit = `CONV_T5;
      3'h6:    limit = `CONV_T6;
      default: limit = `CONV_T0;
    endcase
  end

  // count from start until the selected time is reached
  always @(posedge clock) begin
    if (rst || abort) begin
      count <= 11'h000;
      run   <= 1'b0;
      done  <= 1'b0;
    end else if (load) begin
      count <= 11'h001;
      run   <= 1'b1;
      done  <= 1'b0;
    end else if (run && count >= limit) begin
      run   <= 1'b0;
      done  <= 1'b1;
    end else begin
      count <= run ? count + 11'h001 : count;
      done  <= 1'b0;
    end
  end
endmodule // conv_timer
`default_nettype wire

/* File: src/adc_conversion_sequencer.v */
// Purpose: control logic of a 10-bit eight-input successive approximation converter
// Assumes: AXI4-Lite slave, 32-bit data, one clock, synchronous active high reset
// Notes:   the analog core answers sample_data at the end of each conversion
// Summary of operation
// - single-shot mode plus start write converts the selected channel
// - completion stores result, sets done flag, pulses interrupt together
// - start bit clears itself once conversion begins
// - repeat mode plus start write begins continuous conversion
// - repeat mode restarts automatically after each completion
// - writing disable mode stops conversion at once, discards partial value
// - reading the upper result clears the done flag
// - new start clears done flag; old result held until next completion
// - standby entry aborts conversion and resets both control registers
// - standby entry clears previous results
// - no automatic resume after standby; software restarts
// - ladder is disconnected while in standby
// - each result is 10 bits wide
// - busy set at start, cleared at finish or standby entry
// - time select picks 39 to 1248 clocks; 001 and 111 reserved
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_conversion_sequencer #(
  parameter RES_W = 10
) (
  // clock and reset
  input  wire              clock,
  input  wire              rst,
  // axi4-lite write address
  input  wire [11:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [11:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // power manager
  input  wire              standby_req,
  // analog core
  input  wire [RES_W-1:0]  sample_data,
  output reg  [2:0]        analog_input_pins,
  output reg               analog_input_disable,
  output reg               ladder_connect,
  output reg               sample_enable,
  // event
  output reg               conversion_done_irq
);
  // ***********************************************
  // register state
  // ***********************************************
  reg  [1:0]       operating_mode_field;
  reg  [3:0]       channel_select_field;
  reg              ain_disable;
  reg              ladder_always_connected;
  reg  [2:0]       time_select;
  reg              conversion_done_flag;
  reg              conversion_busy_flag;
  reg  [RES_W-1:0] result;
  reg              in_standby;
  reg  [1:0]       standby_sync;

  // write channel latches
  reg  [11:0]      wr_addr;
  reg              have_aw;
  reg  [31:0]      wr_data;
  reg  [3:0]       wr_strb;
  reg              have_w;

  wire             conv_done;
  wire             do_write = have_aw && have_w && !s_axi_bvalid;
  wire             wr_ctrl  = do_write && wr_addr == `ADDR_CTRL_A && wr_strb[0];
  wire             wr_tim   = do_write && wr_addr == `ADDR_TIMING && wr_strb[0];
  wire             wr_stby  = do_write && wr_addr == `ADDR_STANDBY && wr_strb[0];
  wire             rd_take  = s_axi_arvalid && s_axi_arready;
  wire             rd_upper = rd_take && s_axi_araddr == `ADDR_RES_UPPER;
  wire [1:0]       new_mode = wr_data[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire             standby_now = standby_sync[1] || (wr_stby && wr_data[0]);

  // start on write of one while single-shot or repeat is selected
  wire             mode_ok  = new_mode == `MODE_SINGLE || new_mode == `MODE_REPEAT;
  wire             start_sw = wr_ctrl && wr_data[`CTRL_START_BIT] && mode_ok && !in_standby;
  wire             stop_sw  = wr_ctrl && new_mode == `MODE_DISABLE;
  wire             restart  = conv_done && operating_mode_field == `MODE_REPEAT && !stop_sw;
  wire             start    = (start_sw || restart) && !standby_now;
  wire             abort    = stop_sw || standby_now;

  // ***********************************************
  // conversion timer
  // ***********************************************
  conv_timer u_timer (
    .clock    (clock),
    .rst      (rst),
    .load     (start),
    .abort    (abort),
    .time_sel (time_select),
    .done     (conv_done)
  );

  // ***********************************************
  // standby request synchroniser
  // ***********************************************
  // external power manager is asynchronous to this domain
  always @(posedge clock) begin
    if (rst) begin
      standby_sync <= 2'h0;
    end else begin
      standby_sync <= {standby_sync[0], standby_req};
    end
  end

  // ***********************************************
  // axi write channels
  // ***********************************************
  // address and data accepted in either order, one write in flight
  always @(posedge clock) begin
    if (rst) begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      wr_addr       <= 12'h000;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !have_w && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only addresses answer slverr
        s_axi_bresp  <= (wr_addr == `ADDR_CTRL_A || wr_addr == `ADDR_TIMING ||
                         wr_addr == `ADDR_STANDBY) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***********************************************
  // axi read channels
  // ***********************************************
  // one read at a time, data one cycle after the address is taken
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `ADDR_CTRL_A:    s_axi_rdata <= {24'h0, 1'b0, operating_mode_field, ain_disable, channel_select_field};
          `ADDR_TIMING:    s_axi_rdata <= {24'h0, 2'h0, ladder_always_connected, 1'b1, time_select, 1'b0};
          `ADDR_RES_UPPER: s_axi_rdata <= {24'h0, result[RES_W-1:2]};
          `ADDR_RES_LOWER: s_axi_rdata <= {24'h0, result[1:0], conversion_done_flag, conversion_busy_flag, 4'h0};
          `ADDR_STANDBY:   s_axi_rdata <= {31'h0, in_standby};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************************************
  // control registers and standby
  // ***********************************************
  // standby forces both control registers to reset and blocks writes
  always @(posedge clock) begin
    if (rst || standby_now) begin
      operating_mode_field    <= `MODE_DISABLE;
      channel_select_field    <= 4'h0;
      ain_disable             <= 1'b1;
      ladder_always_connected <= 1'b0;
      time_select             <= 3'h0;
      in_standby              <= !rst;
    end else begin
      if (wr_stby) begin
        in_standby <= 1'b0;
      end
      if (wr_ctrl && !in_standby) begin
        operating_mode_field <= new_mode;
        ain_disable          <= wr_data[`CTRL_AIN_DIS_BIT];
        channel_select_field <= wr_data[3:0];
      end
      if (wr_tim && !in_standby) begin
        ladder_always_connected <= wr_data[`TIM_LADDER_BIT];
        time_select             <= wr_data[3:1];
      end
    end
  end

  // ***********************************************
  // conversion status and result
  // ***********************************************
  // set on completion wins over clear by a result read
  always @(posedge clock) begin
    if (rst || standby_now) begin
      conversion_busy_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      result               <= {RES_W{1'b0}};
      conversion_done_irq  <= 1'b0;
      sample_enable        <= 1'b0;
    end else begin
      conversion_done_irq <= conv_done && !abort;
      if (conv_done && !abort) begin
        result               <= sample_data;
        conversion_done_flag <= 1'b1;
      end else if (start || rd_upper) begin
        conversion_done_flag <= 1'b0;
      end
      if (start) begin
        conversion_busy_flag <= 1'b1;
        sample_enable        <= 1'b1;
      end else if (conv_done || abort) begin
        conversion_busy_flag <= 1'b0;
        sample_enable        <= 1'b0;
      end
    end
  end

  // ***********************************************
  // analog side controls
  // ***********************************************
  // ladder connects only while converting unless held always on
  always @(posedge clock) begin
    if (rst) begin
      analog_input_pins    <= 3'h0;
      analog_input_disable <= 1'b1;
      ladder_connect       <= 1'b0;
    end else begin
      analog_input_pins    <= channel_select_field[2:0];
      analog_input_disable <= ain_disable || channel_select_field[3];
      ladder_connect       <= !standby_now && !in_standby &&
                              (ladder_always_connected || conversion_busy_flag || start);
    end
  end
endmodule // adc_conversion_sequencer
`default_nettype wire

/* File: verif/adc_seq_sva.sv */
// Purpose: port checker for the converter sequencer
// Assumes: standby_req is held for whole cycles
// Notes:   six held cycles cover the two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module adc_seq_sva (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // watched ports
  input wire logic        standby_req,
  input wire logic        sample_enable,
  input wire logic        ladder_connect,
  input wire logic        analog_input_disable,
  input wire logic [2:0]  analog_input_pins,
  input wire logic        conversion_done_irq,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  // ***********************************************
  // assertions
  // ***********************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // standby request seen long enough to have landed
  sequence s_held;
    standby_req [*6];
  endsequence
  sequence s_conv_open;
    (sample_enable && !conversion_done_irq) [*8];
  endsequence
  property p_irq_pulse;
    conversion_done_irq |=> !conversion_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
  property p_irq_conv;
    conversion_done_irq |-> $past(sample_enable, 2);
  endproperty
  a_irq_conv: assert property (p_irq_conv) else $error("irq without conversion");
  property p_conv_min;
    $rose(sample_enable) |-> s_conv_open;
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion ended early");
  property p_sb_idle;
    s_held |-> !sample_enable;
  endproperty
  a_sb_idle: assert property (p_sb_idle) else $error("converting in standby");
  property p_sb_ladder;
    s_held |-> !ladder_connect;
  endproperty
  a_sb_ladder: assert property (p_sb_ladder) else $error("ladder on in standby");
  property p_sb_regs;
    s_held |-> analog_input_disable && analog_input_pins == 3'h0;
  endproperty
  a_sb_regs: assert property (p_sb_regs) else $error("control not reset in standby");
  property p_sb_irq;
    s_held |-> !conversion_done_irq;
  endproperty
  a_sb_irq: assert property (p_sb_irq) else $error("irq in standby");
  property p_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_width: assert property (p_width) else $error("read data above low byte");
endmodule // adc_seq_sva
bind adc_conversion_sequencer adc_seq_sva u_sva (.clock, .rst, .standby_req, .sample_enable,
  .ladder_connect, .analog_input_disable, .analog_input_pins, .conversion_done_irq,
  .s_axi_rvalid, .s_axi_rdata);
`default_nettype wire

/* File: verif/analog_core_model.sv */
// Purpose: behavioural analog core facing the sequencer
// Assumes: the result depends on the channel only
// Notes:   idle output flips so a stale sample never looks valid
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  // clock
  input  wire logic       clock,
  // from the sequencer
  input  wire logic [2:0] channel,
  input  wire logic       enable,
  // result
  output var  logic [9:0] sample_data
);
  // ***********************************************
  // converter answer
  // ***********************************************
  initial sample_data = 10'h155;
  // ten-bit value while converting, toggling when idle
  always @(posedge clock) begin
    sample_data <= enable ? {~channel, 7'h4b} : ~sample_data;
  end
endmodule // analog_core_model
`default_nettype wire

/* File: verif/adc_conversion_sequencer_test.sv */
// Purpose: register-level tests of the converter sequencer
// Assumes: result equals the analog core model's channel pattern
// Notes:   conversion timing is checked within a small latency window
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_conversion_sequencer_test;
  logic        clock = 1'b0, rst = 1'b1, standby_req = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  resp;
  logic [9:0]  r;
  wire         awready, wready, bvalid, arready, rvalid, sample_enable, ladder, ain_dis, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [9:0]  sample_data;
  wire  [2:0]  pins;
  int          error_cnt = 0, comparisons = 0, cyc = 0, irq_cnt = 0, t0, a1, a2, k;
  adc_conversion_sequencer u_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .standby_req(standby_req), .sample_data(sample_data),
    .analog_input_pins(pins), .analog_input_disable(ain_dis), .ladder_connect(ladder),
    .sample_enable(sample_enable), .conversion_done_irq(irq));
  analog_core_model u_core (.clock(clock), .channel(pins), .enable(sample_enable),
    .sample_data(sample_data));
  // ***********************************************
  // clock, cycle and event counters
  // ***********************************************
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // latency of the register path is not fixed, so allow a window
  task automatic chk_win(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? lo : v, lo);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask
  task automatic wait_irq(output int at);
    int n;
    n = irq_cnt;
    while (irq_cnt == n) @(posedge clock);
    at = cyc;
  endtask
  function automatic int conv_t(input int c);
    case (c)
      2: return `CONV_T2;
      3: return `CONV_T3;
      4: return `CONV_T4;
      5: return `CONV_T5;
      6: return `CONV_T6;
      default: return `CONV_T0;
    endcase
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ***********************************************
  // tests
  // ***********************************************
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd_reg(`ADDR_CTRL_A, rd);
    chk(rd, {24'h0, `CTRL_A_RESET});
    rd_reg(12'h100, rd);
    chk({resp, rd[29:0]}, {2'h2, 30'h0});
    // result registers are read only, so a write answers slverr
    wr(`ADDR_RES_UPPER, 32'h0);
    chk(resp, 32'h2);
    $display("reset test done");
    // every time code, reserved ones included, on a matching channel
    for (int c = 0; c < 8; c++) begin
      r = {~c[2:0], 7'h4b};
      wr(`ADDR_TIMING, 32'h10 | (c << 1));
      wr(`ADDR_CTRL_A, 32'h80 | (`MODE_SINGLE << 5) | c);
      t0 = cyc;
      rd_reg(`ADDR_RES_LOWER, rd);
      chk(rd & 32'h30, 32'h10);
      rd_reg(`ADDR_CTRL_A, rd);
      chk({rd[7], ladder, pins}, {2'b01, c[2:0]});
      wait_irq(a1);
      chk_win(a1 - t0, conv_t(c), conv_t(c) + 6);
      rd_reg(`ADDR_RES_LOWER, rd);
      chk(rd & 32'hf0, {24'h0, r[1:0], 6'h20});
      rd_reg(`ADDR_RES_UPPER, rd);
      chk(rd, {24'h0, r[9:2]});
      rd_reg(`ADDR_RES_LOWER, rd);
      chk(rd & 32'h20, 32'h0);
    end
    $display("single test done");
    wr(`ADDR_TIMING, 32'h10);
    chk(resp, 32'h0);
    wr(`ADDR_CTRL_A, 32'ha2);
    wait_irq(a1);
    wr(`ADDR_CTRL_A, 32'ha5);
    rd_reg(`ADDR_RES_LOWER, rd);
    chk(rd & 32'h30, 32'h10);
    rd_reg(`ADDR_RES_UPPER, rd);
    chk(rd, 32'hb2);
    wait_irq(a1);
    rd_reg(`ADDR_RES_UPPER, rd);
    chk(rd, 32'h52);
    $display("restart test done");
    wr(`ADDR_CTRL_A, 32'h80 | (`MODE_REPEAT << 5) | 3);
    wait_irq(a1);
    wait_irq(a2);
    chk_win(a2 - a1, `CONV_T0, `CONV_T0 + 2);
    wait_irq(a1);
    chk_win(a1 - a2, `CONV_T0, `CONV_T0 + 2);
    rd_reg(`ADDR_RES_UPPER, rd);
    wr(`ADDR_CTRL_A, 32'h03);
    k = irq_cnt;
    repeat (100) @(posedge clock);
    rd_reg(`ADDR_RES_LOWER, rd);
    chk(irq_cnt, k);
    chk(rd & 32'h30, 32'h0);
    $display("repeat test done");
    wr(`ADDR_TIMING, 32'h6);
    wr(`ADDR_CTRL_A, 32'ha1);
    repeat (10) @(posedge clock);
    standby_req <= 1'b1;
    repeat (20) @(posedge clock);
    rd_reg(`ADDR_TIMING, rd);
    chk(rd, {24'h0, `TIMING_RESET});
    rd_reg(`ADDR_RES_UPPER, rd);
    chk(rd, 32'h0);
    rd_reg(`ADDR_RES_LOWER, rd);
    chk(rd & 32'hf0, 32'h0);
    rd_reg(`ADDR_CTRL_A, rd);
    chk(rd, {24'h0, `CTRL_A_RESET});
    standby_req <= 1'b0;
    k = irq_cnt;
    repeat (1400) @(posedge clock);
    chk(irq_cnt, k);
    // standby stays until software leaves it through the standby word
    rd_reg(`ADDR_STANDBY, rd);
    chk(rd, 32'h1);
    wr(`ADDR_STANDBY, 32'h0);
    rd_reg(`ADDR_STANDBY, rd);
    chk(rd, 32'h0);
    $display("standby test done");
    complete_run;
  end
  // watchdog well beyond the expected run of about 4600 cycles
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    complete_run;
  end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
